// ---- src/aes_engine.v ----
// Summary of operation
// - Encrypts or decrypts one 16-byte block with a 128-bit key, direction preset.
// - Operation completes 375 clock cycles after start; then state holds result.
// - Completion raises the interrupt only when the completion interrupt is enabled.
// - Completion issues a one-cycle DMA trigger.
// - With auto start, writing the last state word starts the operation.
// - In XOR load mode, state writes XOR into the held state.
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "aes_engine_regs.vh"

module aes_engine (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Events
    output wire irq,
    output reg dmaTrig
);

    // GF(2^8) multiply
    function [7:0] gm;
        input [7:0] a;
        input [7:0] b;
        integer i;
        reg [7:0] p;
        reg [7:0] x;
        begin
            p = 8'h00;
            x = a;
            for (i = 0; i < 8; i = i + 1) begin
                if (b[i]) p = p ^ x;
                x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1b : 8'h00);
            end
            gm = p;
        end
    endfunction

    // Multiplicative inverse as a^254, zero maps to zero
    function [7:0] ginv;
        input [7:0] a;
        reg [7:0] a2, a3, a12, a15, a240;
        begin
            a2 = gm(a, a);
            a3 = gm(a2, a);
            a12 = gm(gm(a3, a3), gm(a3, a3));
            a15 = gm(a12, a3);
            a240 = gm(a15, a15);
            a240 = gm(a240, a240);
            a240 = gm(a240, a240);
            a240 = gm(a240, a240);
            ginv = gm(gm(a240, a12), a2);
        end
    endfunction

    // Forward substitution
    function [7:0] sb;
        input [7:0] a;
        reg [7:0] b;
        begin
            b = ginv(a);
            sb = b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]}
                ^ {b[3:0], b[7:4]} ^ 8'h63;
        end
    endfunction

    // Inverse substitution
    function [7:0] isb;
        input [7:0] a;
        begin
            isb = ginv({a[6:0], a[7]} ^ {a[4:0], a[7:5]} ^ {a[1:0], a[7:2]} ^ 8'h05);
        end
    endfunction

    // Byte substitution with row shift, byte 0 in the top bits
    function [127:0] subShift;
        input [127:0] s;
        input inv;
        integer c, r, src;
        reg [127:0] t;
        begin
            t = 128'h0;
            for (c = 0; c < 4; c = c + 1) begin
                for (r = 0; r < 4; r = r + 1) begin
                    src = inv ? (((c - r + 4) % 4) * 4 + r) : (((c + r) % 4) * 4 + r);
                    t[127 - 8 * (c * 4 + r) -: 8] = inv ? isb(s[127 - 8 * src -: 8])
                        : sb(s[127 - 8 * src -: 8]);
                end
            end
            subShift = t;
        end
    endfunction

    // Column mixing, forward or inverse coefficients
    function [127:0] mixAll;
        input [127:0] s;
        input inv;
        integer c, r, j;
        reg [31:0] m;
        reg [7:0] acc;
        reg [127:0] t;
        begin
            t = 128'h0;
            m = inv ? 32'h0e0b0d09 : 32'h02030101;
            for (c = 0; c < 4; c = c + 1) begin
                for (r = 0; r < 4; r = r + 1) begin
                    acc = 8'h00;
                    for (j = 0; j < 4; j = j + 1)
                        acc = acc ^ gm(s[127 - 8 * (c * 4 + (r + j) % 4) -: 8],
                            m[31 - 8 * j -: 8]);
                    t[127 - 8 * (c * 4 + r) -: 8] = acc;
                end
            end
            mixAll = t;
        end
    endfunction

    // Key schedule word transform
    function [31:0] keyT;
        input [31:0] w;
        input [7:0] rc;
        begin
            keyT = {sb(w[23:16]) ^ rc, sb(w[15:8]), sb(w[7:0]), sb(w[31:24])};
        end
    endfunction

    // Next round key
    function [127:0] keyNext;
        input [127:0] k;
        input [7:0] rc;
        reg [31:0] n0, n1, n2;
        begin
            n0 = k[127:96] ^ keyT(k[31:0], rc);
            n1 = k[95:64] ^ n0;
            n2 = k[63:32] ^ n1;
            keyNext = {n0, n1, n2, k[31:0] ^ n2};
        end
    endfunction

    // Previous round key
    function [127:0] keyPrev;
        input [127:0] k;
        input [7:0] rc;
        reg [31:0] w3;
        begin
            w3 = k[31:0] ^ k[63:32];
            keyPrev = {k[127:96] ^ keyT(w3, rc), k[95:64] ^ k[127:96],
                k[63:32] ^ k[95:64], w3};
        end
    endfunction

    // Reset release through two flip-flops
    reg [1:0] rstPipe;
    wire rstLocal = rstPipe[1];
    always @(posedge clock or negedge rstn) begin
        if (!rstn) rstPipe <= 2'b00;
        else rstPipe <= {rstPipe[0], 1'b1};
    end

    // Bus address phase capture
    reg phWrite;
    reg [5:0] phAddr;
    wire addrPhase = hsel & hready & htrans[`AES_HTRANS_NONSEQ];
    always @(posedge clock or negedge rstLocal) begin
        if (!rstLocal) begin
            phWrite <= 1'b0;
            phAddr <= 6'h00;
        end else begin
            phWrite <= addrPhase & hwrite;
            phAddr <= haddr[5:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Engine state
    reg [2:0] ctrl;
    reg maskDone;
    reg done;
    reg busy;
    reg [8:0] cnt;
    reg [127:0] key;
    reg [127:0] st;
    reg [127:0] rk;
    reg [7:0] rc;
    reg opDec;

    // Write decode
    wire wrCtrl = phWrite & (phAddr == `AES_OFF_CTRL);
    wire wrStatus = phWrite & (phAddr == `AES_OFF_STATUS);
    wire wrMask = phWrite & (phAddr == `AES_OFF_IMASK);
    wire wrKey = phWrite & ((phAddr & `AES_OFF_MASK) == `AES_OFF_KEY) & ~busy;
    wire wrState = phWrite & ((phAddr & `AES_OFF_MASK) == `AES_OFF_STATE) & ~busy;
    wire [1:0] wordIdx = phAddr[3:2];
    // Direction of a new operation, taken from the start write itself when it carries one
    wire startDec = wrCtrl ? hwdata[`AES_CTRL_DEC] : ctrl[`AES_CTRL_DEC - 1];
    // Direction latched at start, so a control write mid-operation cannot flip it
    wire isDec = opDec;

    // State word merge, replace or XOR load
    reg [127:0] loadSt;
    always @* begin
        loadSt = st;
        if (wrState)
            loadSt[127 - 32 * wordIdx -: 32] = ctrl[`AES_CTRL_XOR - 1]
                ? (st[127 - 32 * wordIdx -: 32] ^ hwdata) : hwdata;
    end

    // Start by command or by last state word with auto start
    wire startCmd = wrCtrl & hwdata[`AES_CTRL_START] & ~busy;
    wire startAuto = wrState & ctrl[`AES_CTRL_AUTO - 1] & (wordIdx == `AES_LAST_WORD);
    wire startOp = startCmd | startAuto;
    wire finish = busy & (cnt == `AES_CNT_LAST);

    // Control, mask and status registers
    always @(posedge clock or negedge rstLocal) begin
        if (!rstLocal) begin
            ctrl <= `AES_CTRL_RST;
            maskDone <= `AES_IMASK_RST;
            done <= 1'b0;
            dmaTrig <= 1'b0;
        end else begin
            if (wrCtrl) ctrl <= hwdata[`AES_CTRL_XOR:`AES_CTRL_DEC];
            if (wrMask) maskDone <= hwdata[`AES_ST_DONE];
            // Completion wins over any clear in the same cycle
            if (finish) done <= 1'b1;
            else if (startOp | (wrStatus & hwdata[`AES_ST_DONE])) done <= 1'b0;
            dmaTrig <= finish;
        end
    end

    assign irq = done & maskDone;

    // Cipher datapath: rounds early, then idle until the fixed count ends
    always @(posedge clock or negedge rstLocal) begin
        if (!rstLocal) begin
            busy <= 1'b0;
            cnt <= 9'd0;
            key <= 128'h0;
            st <= 128'h0;
            rk <= 128'h0;
            rc <= 8'h00;
            opDec <= 1'b0;
        end else begin
            if (wrKey) key[127 - 32 * wordIdx -: 32] <= hwdata;
            if (startOp) begin
                busy <= 1'b1;
                cnt <= 9'd0;
                rk <= key;
                rc <= `AES_RCON_FIRST;
                opDec <= startDec;
                st <= startDec ? loadSt : (loadSt ^ key);
            end else begin
                if (wrState) st <= loadSt;
                if (busy) begin
                    cnt <= cnt + 9'd1;
                    if (finish) busy <= 1'b0;
                    if (!isDec && cnt <= `AES_ROUND_LAST) begin
                        // Encryption round with freshly expanded key
                        rk <= keyNext(rk, rc);
                        rc <= gm(rc, 8'h02);
                        st <= (cnt == `AES_ROUND_LAST)
                            ? (subShift(st, 1'b0) ^ keyNext(rk, rc))
                            : (mixAll(subShift(st, 1'b0), 1'b0) ^ keyNext(rk, rc));
                    end else if (isDec && cnt < `AES_ROUND_LAST) begin
                        // Expand forward to the final round key
                        rk <= keyNext(rk, rc);
                        rc <= gm(rc, 8'h02);
                    end else if (isDec && cnt == `AES_ROUND_LAST) begin
                        rk <= keyNext(rk, rc);
                    end else if (isDec && cnt == `AES_DEC_ADDKEY) begin
                        st <= st ^ rk;
                    end else if (isDec && cnt <= `AES_DEC_LAST) begin
                        // Inverse round stepping the key schedule backwards
                        rk <= keyPrev(rk, rc);
                        rc <= rc[0] ? (((rc ^ 8'h1b) >> 1) | 8'h80) : (rc >> 1);
                        st <= (cnt == `AES_DEC_LAST)
                            ? (subShift(st, 1'b1) ^ keyPrev(rk, rc))
                            : mixAll(subShift(st, 1'b1) ^ keyPrev(rk, rc), 1'b1);
                    end
                end
            end
        end
    end

    // Read data registered in the address phase
    always @(posedge clock or negedge rstLocal) begin
        if (!rstLocal) begin
            hrdata <= 32'h0;
        end else if (addrPhase & ~hwrite) begin
            hrdata <= 32'h0;
            if (haddr[5:0] == `AES_OFF_CTRL)
                hrdata[`AES_CTRL_XOR:`AES_CTRL_DEC] <= ctrl;
            else if (haddr[5:0] == `AES_OFF_STATUS)
                hrdata[`AES_ST_BUSY:`AES_ST_DONE] <= {busy, done};
            else if (haddr[5:0] == `AES_OFF_IMASK)
                hrdata[`AES_ST_DONE] <= maskDone;
            else if ((haddr[5:0] & `AES_OFF_MASK) == `AES_OFF_STATE && !busy)
                hrdata <= st[127 - 32 * haddr[3:2] -: 32];
        end
    end

endmodule // aes_engine

// ---- src/aes_engine_regs.vh ----
`ifndef AES_ENGINE_REGS_VH
`define AES_ENGINE_REGS_VH

// Register byte offsets
`define AES_OFF_CTRL 6'h00
`define AES_OFF_STATUS 6'h04
`define AES_OFF_IMASK 6'h08
`define AES_OFF_KEY 6'h10
`define AES_OFF_STATE 6'h20
`define AES_OFF_MASK 6'h30

// Control fields
`define AES_CTRL_START 0
`define AES_CTRL_DEC 1
`define AES_CTRL_AUTO 2
`define AES_CTRL_XOR 3

// Status fields
`define AES_ST_DONE 0
`define AES_ST_BUSY 1

// Reset values
`define AES_CTRL_RST 3'h0
`define AES_IMASK_RST 1'b0

// Operation timing in peripheral clock cycles
`define AES_OP_CYCLES 9'd375
`define AES_CNT_LAST 9'd374
`define AES_ROUND_LAST 9'd9
`define AES_DEC_ADDKEY 9'd10
`define AES_DEC_LAST 9'd20

// Cipher, state word and bus constants
`define AES_RCON_FIRST 8'h01
`define AES_LAST_WORD 2'h3
`define AES_HTRANS_NONSEQ 1'b1

`endif

// ---- dv/aes_engine_checker.sv ----
`timescale 1ns/1ps
`include "aes_engine_regs.vh"

module aes_engine_checker (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // Bus
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    // Events
    input wire irq,
    input wire dmaTrig
);
    reg wrPend;
    reg [5:0] wrAddr;
    reg autoBit;
    reg maskBit;
    reg [8:0] cnt;
    wire ctrlWr = wrPend && wrAddr == `AES_OFF_CTRL;
    wire lastWr = wrPend && wrAddr == 6'h2c;
    wire startEv = cnt == 9'd0 && ((ctrlWr && hwdata[0]) || (autoBit && lastWr));
    wire clrEv = cnt == 9'd0 && wrPend && wrAddr == `AES_OFF_STATUS && hwdata[0];

    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    // Shadow of write data phases, mask, auto start and the operation count
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wrPend <= 1'b0;
            wrAddr <= 6'h00;
            autoBit <= 1'b0;
            maskBit <= 1'b0;
            cnt <= 9'd0;
        end else begin
            wrPend <= hsel && hreadyout && htrans[1] && hwrite;
            wrAddr <= haddr[5:0];
            if (ctrlWr) autoBit <= hwdata[`AES_CTRL_AUTO];
            if (wrPend && wrAddr == `AES_OFF_IMASK) maskBit <= hwdata[0];
            if (startEv) cnt <= 9'd1;
            else if (cnt != 9'd0) cnt <= (cnt == 9'd375) ? 9'd0 : cnt + 9'd1;
        end
    end

    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait OKAY");
    AST_DMA_PULSE: assert property (dmaTrig |=> !dmaTrig)
        else $error("dma trigger longer than one cycle");
    AST_DONE_TIME: assert property (cnt == 9'd375 |=> dmaTrig)
        else $error("dma trigger missing after operation");
    AST_NO_EARLY: assert property (dmaTrig |-> $past(cnt) == 9'd375)
        else $error("dma trigger at wrong time");
    AST_IRQ_ON_DONE: assert property (dmaTrig && maskBit |-> irq)
        else $error("enabled completion without irq");
    AST_IRQ_MASKED: assert property (!maskBit && !$past(maskBit) |-> !irq)
        else $error("irq while disabled");
    AST_DONE_CLEAR: assert property (clrEv |=> ##1 !irq)
        else $error("irq stays after done clear");
    AST_START_CLEAR: assert property (startEv |=> ##1 !irq)
        else $error("irq stays after start");
    AST_READ_HOLD: assert property (!(hsel && htrans[1] && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without read");

    // Main scenarios
    cover property (startEv && autoBit);
    cover property (dmaTrig && irq);
    cover property (clrEv);
endmodule // aes_engine_checker

bind aes_engine aes_engine_checker i_aes_engine_checker (.clock(clock), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .dmaTrig(dmaTrig));

// ---- dv/aes_ahb_master.sv ----
`timescale 1ns/1ps

module aes_ahb_master (
    // Clock
    input wire clock,
    // Bus request
    output reg hsel,
    output reg [31:0] haddr,
    output reg [1:0] htrans,
    output reg hwrite,
    output reg [2:0] hsize,
    output reg [31:0] hwdata,
    // Bus answer
    input wire hready,
    input wire [31:0] hrdata
);
    // Idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // Address phase held until taken, then data phase held until ready
    task busCycle(input [5:0] a, input w, input [31:0] d);
        begin
            @(posedge clock);
            hsel <= 1'b1;
            haddr <= {26'h0, a};
            htrans <= 2'h2;
            hwrite <= w;
            do @(posedge clock); while (!hready);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            do @(posedge clock); while (!hready);
            hwdata <= ~d;
        end
    endtask

    task busWrite(input [5:0] a, input [31:0] d);
        busCycle(a, 1'b1, d);
    endtask

    task busRead(input [5:0] a, output [31:0] d);
        begin
            busCycle(a, 1'b0, 32'h0);
            d = hrdata;
        end
    endtask
endmodule // aes_ahb_master

// ---- dv/aes_engine_tb_top.sv ----
`timescale 1ns/1ps
`include "aes_engine_regs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("FAIL %0s exp %h got %h", n, e, g); end end

module aes_engine_tb_top;
    reg clock = 1'b0;
    reg rstn = 1'b0;
    wire hsel, hwrite, hready, hresp, irq, dmaTrig;
    wire [1:0] htrans;
    wire [2:0] hsize;
    wire [31:0] haddr, hwdata, hrdata;
    integer failures = 0;
    integer compares = 0;
    integer n;
    reg [31:0] rdat;
    localparam [127:0] KEY = 128'h000102030405060708090a0b0c0d0e0f;
    localparam [127:0] PLAIN = 128'h00112233445566778899aabbccddeeff;
    localparam [127:0] CIPHER = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;

    // 25 MHz clock
    always #20 clock = ~clock;

    aes_ahb_master i_aes_ahb_master (.clock(clock), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata));
    aes_engine i_aes_engine (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .irq(irq), .dmaTrig(dmaTrig));

    task wr(input [5:0] a, input [31:0] d);
        i_aes_ahb_master.busWrite(a, d);
    endtask

    task rd(input [5:0] a, input [31:0] e);
        begin
            i_aes_ahb_master.busRead(a, rdat);
            `CHK($sformatf("reg %h", a), e, rdat)
        end
    endtask

    // Writes or checks the four words of a block, first byte in word 0
    task blk(input [5:0] b, input [127:0] v, input w);
        integer i;
        begin
            for (i = 0; i < 4; i++)
                if (w) wr(6'(b + 4 * i), v[127 - 32 * i -: 32]);
                else rd(6'(b + 4 * i), v[127 - 32 * i -: 32]);
        end
    endtask

    // Counts edges until the completion trigger
    task waitOp;
        begin
            n = 0;
            do begin
                @(posedge clock);
                #1;
                n++;
            end while (!dmaTrig && n < 1000);
        end
    endtask

    task summarize;
        begin
            $display("compares %0d failures %0d", compares, failures);
            if (failures == 0 && compares > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (4000) @(posedge clock);
        failures++;
        summarize;
    end

    // Test sequence
    initial begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        rd(`AES_OFF_CTRL, 32'h0);
        rd(`AES_OFF_STATUS, 32'h0);
        rd(`AES_OFF_IMASK, 32'h0);
        wr(6'h0c, 32'hffffffff);
        rd(6'h0c, 32'h0);
        $display("test reset done");
        wr(`AES_OFF_IMASK, 32'h1);
        blk(`AES_OFF_KEY, KEY, 1'b1);
        blk(`AES_OFF_STATE, PLAIN, 1'b1);
        wr(`AES_OFF_CTRL, 32'h1);
        rd(`AES_OFF_STATUS, 32'h2);
        waitOp;
        `CHK("enc cycles", 375 - 3, n)
        `CHK("irq", 1'b1, irq)
        rd(`AES_OFF_STATUS, 32'h1);
        blk(`AES_OFF_STATE, CIPHER, 1'b0);
        wr(`AES_OFF_STATUS, 32'h1);
        rd(`AES_OFF_STATUS, 32'h0);
        `CHK("irq", 1'b0, irq)
        $display("test encrypt done");
        wr(`AES_OFF_IMASK, 32'h0);
        wr(`AES_OFF_CTRL, 32'h6);
        rd(`AES_OFF_CTRL, 32'h6);
        blk(`AES_OFF_STATE, CIPHER, 1'b1);
        waitOp;
        `CHK("auto cycles", 375, n)
        `CHK("irq", 1'b0, irq)
        blk(`AES_OFF_STATE, PLAIN, 1'b0);
        $display("test decrypt done");
        wr(`AES_OFF_CTRL, 32'h8);
        blk(`AES_OFF_STATE, ~128'h0, 1'b1);
        blk(`AES_OFF_STATE, ~PLAIN, 1'b0);
        $display("test xor done");
        wr(`AES_OFF_CTRL, 32'h0);
        blk(`AES_OFF_STATE, CIPHER, 1'b1);
        wr(`AES_OFF_CTRL, 32'h3);
        rd(`AES_OFF_STATUS, 32'h2);
        rd(`AES_OFF_STATE, 32'h0);
        wr(`AES_OFF_STATE, 32'h0);
        waitOp;
        `CHK("dec cycles", 375 - 9, n)
        blk(`AES_OFF_STATE, PLAIN, 1'b0);
        $display("test direct decrypt done");
        summarize;
    end
endmodule // aes_engine_tb_top
